// file: hw/ist_pkg.sv
// Purpose: shared constants and carriers for the slave-transmit port
// Assumes: single system clock, pins synchronised inside the block
// Notes:   no software bus; control and status are plain ports
package ist_pkg;

  // ----------------------------------------------------------------
  // field positions, reset values and count limits
  // ----------------------------------------------------------------
  localparam int unsigned CTL_CLOCK_RELEASE_BIT = 4;
  localparam logic [7:0]  CTL_RESET_VALUE       = 8'h00;
  localparam logic [7:0]  BYTE_RESET_VALUE      = 8'h00;
  localparam logic [3:0]  BIT_COUNT_RESET       = 4'h0;
  localparam logic [3:0]  ACK_CLOCK_NUMBER      = 4'h9;
  localparam logic [3:0]  LAST_DATA_CLOCK       = 4'h8;
  localparam logic [1:0]  SYNC_RESET_VALUE      = 2'h3;
  localparam logic [1:0]  BUF_COUNT_RESET       = 2'h0;
  localparam logic [1:0]  BUF_DEPTH             = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr_byte;   // matched address byte from address logic
    logic       read_dir;    // direction bit of that byte
  } ist_match_s;

  typedef struct packed {
    logic read_direction;    // read-direction flag of the status
    logic byte_done;         // last byte finished
    logic nack_seen;         // last acknowledge was high
  } ist_status_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACK_ADDR,
    ST_STRETCH,
    ST_SHIFT,
    ST_ACK_WAIT
  } ist_state_e;

endpackage : ist_pkg

// file: hw/ist_slave_tx.sv
// Purpose: slave-transmitter path of a two-wire serial port
// Assumes: address match done outside; bus pins asynchronous
// Notes:   pins are open drain; output enable low means pulling low
`timescale 1ns/1ns
`default_nettype none
module ist_slave_tx
  import ist_pkg::*;
(
  input  wire logic              sys_clk,        // system clock, 50 MHz
  input  wire logic              rst,            // sync reset, active high
  input  wire ist_pkg::ist_match_s match_in,     // matched address data
  input  wire logic              match_valid,    // pulse: address matched
  input  wire logic [7:0]        wr_data,        // byte to transmit
  input  wire logic              wr_valid,       // write into data buffer
  output logic                   wr_ready,       // buffer can take a byte
  input  wire logic [7:0]        ctl_wdata,      // control register value
  input  wire logic              ctl_we,         // control register write
  input  wire logic              irq_clear,      // pulse: clear irq flag
  output logic [7:0]             data_buffer,    // serial data buffer
  output logic [7:0]             ctl_rdata,      // serial port control
  output ist_pkg::ist_status_s   status,         // serial port status
  output logic                   irq_flag,       // serial port irq flag
  input  wire logic              scl_in,         // shared clock pin level
  output logic                   scl_oe_n,       // low: pull clock low
  input  wire logic              sda_in,         // data pin level
  output logic                   sda_oe_n        // low: pull data low
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // index 0 is the clock pin, index 1 the data pin; both reset to the
  // released bus level so that no false edge follows reset
  logic [1:0] pin_raw;
  logic [1:0] pin_s;
  logic       scl_last_reg, scl_last_next;

  assign pin_raw = {sda_in, scl_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      logic [1:0] sync_reg, sync_next;

      always_comb begin
        sync_next = {sync_reg[0], pin_raw[gi]};
      end

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          sync_reg <= SYNC_RESET_VALUE;
        end else begin
          sync_reg <= sync_next;
        end
      end

      // only the second stage is seen by the logic
      assign pin_s[gi] = sync_reg[1];
    end
  endgenerate

  always_comb begin
    scl_last_next = pin_s[0];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_last_reg <= 1'b1;
    end else begin
      scl_last_reg <= scl_last_next;
    end
  end

  logic scl_s, sda_s, scl_rise, scl_fall;
  assign scl_s    = pin_s[0];
  assign sda_s    = pin_s[1];
  // edges lag the pin by two clocks, so the master's low and high
  // times must each span several system clocks
  assign scl_rise = scl_s & ~scl_last_reg;
  assign scl_fall = ~scl_s & scl_last_reg;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // room in the buffer is decoded for the push and for the ready flag
  function automatic logic buf_room(input logic [1:0] cnt);
    return (cnt != BUF_DEPTH);
  endfunction : buf_room

  // ----------------------------------------------------------------
  // two-entry transmit buffer
  // ----------------------------------------------------------------
  // a word written while the shifter is busy waits here, so a stall
  // on the bus side never drops a byte from software
  logic [7:0] buf_mem_reg  [2];
  logic [7:0] buf_mem_next [2];
  logic [1:0] buf_cnt_reg, buf_cnt_next;
  logic       buf_pop;
  logic       buf_valid;
  logic       buf_ready;

  assign buf_valid = (buf_cnt_reg != BUF_COUNT_RESET);
  assign buf_ready = buf_room(buf_cnt_reg);

  always_comb begin
    logic push;
    push         = wr_valid & buf_ready;
    buf_mem_next = buf_mem_reg;
    buf_cnt_next = buf_cnt_reg;
    if (buf_pop & buf_valid) begin
      buf_mem_next[0] = buf_mem_reg[1];
      buf_cnt_next    = buf_cnt_next - 2'h1;
    end
    if (push) begin
      buf_mem_next[buf_cnt_next[0]] = wr_data;
      buf_cnt_next                  = buf_cnt_next + 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      buf_mem_reg[0] <= BYTE_RESET_VALUE;
      buf_mem_reg[1] <= BYTE_RESET_VALUE;
      buf_cnt_reg    <= BUF_COUNT_RESET;
    end else begin
      buf_mem_reg <= buf_mem_next;
      buf_cnt_reg <= buf_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // transmit sequencer
  // ----------------------------------------------------------------
  ist_state_e  state_reg, state_next;
  logic [7:0]  shift_reg, shift_next;
  logic [7:0]  dbuf_reg, dbuf_next;
  logic [7:0]  ctl_reg, ctl_next;
  logic [3:0]  bitcnt_reg, bitcnt_next;
  ist_status_s stat_reg, stat_next;
  logic        irq_reg, irq_next;
  logic        scl_oe_n_reg, scl_oe_n_next;
  logic        sda_oe_n_reg, sda_oe_n_next;
  logic        wr_ready_reg, wr_ready_next;
  logic        loaded_reg, loaded_next;

  always_comb begin
    logic irq_set;
    irq_set       = 1'b0;
    state_next    = state_reg;
    shift_next    = shift_reg;
    dbuf_next     = dbuf_reg;
    ctl_next      = ctl_reg;
    bitcnt_next   = bitcnt_reg;
    stat_next     = stat_reg;
    scl_oe_n_next = scl_oe_n_reg;
    sda_oe_n_next = sda_oe_n_reg;
    loaded_next   = loaded_reg;
    buf_pop       = 1'b0;
    if (ctl_we) begin
      ctl_next = ctl_wdata;
    end
    case (state_reg)
      ST_IDLE: begin
        scl_oe_n_next = 1'b1;
        sda_oe_n_next = 1'b1;
        if (match_valid & match_in.read_dir) begin
          stat_next.read_direction = 1'b1;
          dbuf_next                = match_in.addr_byte;
          sda_oe_n_next            = 1'b0;
          state_next               = ST_ACK_ADDR;
        end
      end
      ST_ACK_ADDR: begin
        // acknowledge holds through the ninth clock, then stretch
        if (scl_fall) begin
          sda_oe_n_next               = 1'b1;
          scl_oe_n_next               = 1'b0;
          ctl_next[CTL_CLOCK_RELEASE_BIT] = 1'b0;
          irq_set                     = 1'b1;
          loaded_next                 = 1'b0;
          state_next                  = ST_STRETCH;
        end
      end
      ST_STRETCH: begin
        // a byte is taken only while the clock is held, so the shifter
        // never changes under a running transfer
        if (!loaded_reg & buf_valid) begin
          buf_pop     = 1'b1;
          dbuf_next   = buf_mem_reg[0];
          shift_next  = buf_mem_reg[0];
          loaded_next = 1'b1;
        end
        // first bit is set up while the clock is still held low
        sda_oe_n_next = ~loaded_reg | shift_reg[7];
        if (ctl_reg[CTL_CLOCK_RELEASE_BIT] & loaded_reg) begin
          scl_oe_n_next = 1'b1;
          bitcnt_next   = 4'h1;
          state_next    = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        // master clocks only once the line is free; bits move on fall
        if (scl_fall) begin
          bitcnt_next = bitcnt_reg + 4'h1;
          if (bitcnt_reg == LAST_DATA_CLOCK) begin
            sda_oe_n_next = 1'b1;
            state_next    = ST_ACK_WAIT;
          end else begin
            shift_next    = {shift_reg[6:0], 1'b0};
            sda_oe_n_next = shift_reg[6];
          end
        end
      end
      ST_ACK_WAIT: begin
        // data line is released here; the master owns it for the
        // acknowledge, sampled on the rise and acted on at the fall
        if (scl_rise) begin
          stat_next.nack_seen = sda_s;
          stat_next.byte_done = 1'b1;
        end
        if (scl_fall) begin
          irq_set = 1'b1;
          if (stat_reg.nack_seen) begin
            stat_next     = '0;
            scl_oe_n_next = 1'b1;
            sda_oe_n_next = 1'b1;
            state_next    = ST_IDLE;
          end else begin
            // software loads the next byte and releases the clock
            scl_oe_n_next                   = 1'b0;
            ctl_next[CTL_CLOCK_RELEASE_BIT] = 1'b0;
            loaded_next                     = 1'b0;
            state_next                      = ST_STRETCH;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // set wins over a clear in the same cycle
    irq_next      = irq_set | (irq_reg & ~irq_clear);
    wr_ready_next = buf_room(buf_cnt_next);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg    <= ST_IDLE;
      shift_reg    <= BYTE_RESET_VALUE;
      dbuf_reg     <= BYTE_RESET_VALUE;
      ctl_reg      <= CTL_RESET_VALUE;
      bitcnt_reg   <= BIT_COUNT_RESET;
      stat_reg     <= '0;
      irq_reg      <= 1'b0;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      wr_ready_reg <= 1'b0;
      loaded_reg   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      shift_reg    <= shift_next;
      dbuf_reg     <= dbuf_next;
      ctl_reg      <= ctl_next;
      bitcnt_reg   <= bitcnt_next;
      stat_reg     <= stat_next;
      irq_reg      <= irq_next;
      scl_oe_n_reg <= scl_oe_n_next;
      sda_oe_n_reg <= sda_oe_n_next;
      wr_ready_reg <= wr_ready_next;
      loaded_reg   <= loaded_next;
    end
  end

  assign wr_ready    = wr_ready_reg;
  assign data_buffer = dbuf_reg;
  assign ctl_rdata   = ctl_reg;
  assign status      = stat_reg;
  assign irq_flag    = irq_reg;
  assign scl_oe_n    = scl_oe_n_reg;
  assign sda_oe_n    = sda_oe_n_reg;

endmodule : ist_slave_tx
`default_nettype wire

// file: test/ist_slave_tx_asserts.sv
// Purpose: port checks for the slave-transmit block
// Assumes: one clock, sync reset
// Notes:   bound to every instance
`timescale 1ns/1ns
`default_nettype none
module ist_slave_tx_asserts
  import ist_pkg::*;
(
  input wire logic                 sys_clk,     // clock
  input wire logic                 rst,         // reset
  input wire ist_pkg::ist_match_s  match_in,    // match data
  input wire logic                 match_valid, // match strobe
  input wire logic                 irq_clear,   // irq clear
  input wire logic [7:0]           ctl_rdata,   // control
  input wire ist_pkg::ist_status_s status,      // status
  input wire logic                 irq_flag,    // irq
  input wire logic                 scl_in,      // clock pin
  input wire logic                 scl_oe_n,    // clock pull
  input wire logic                 sda_oe_n     // data pull
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic rel = ctl_rdata[CTL_CLOCK_RELEASE_BIT];
  sequence s_rd;
    match_valid && match_in.read_dir && !status.read_direction;
  endsequence
  property p_rd; s_rd |-> ##[1:3] status.read_direction; endproperty
  a_rd: assert property (p_rd) else $error("no read flag");
  property p_ack; s_rd |=> !sda_oe_n; endproperty
  a_ack: assert property (p_ack) else $error("no address ack");
  property p_st; $fell(scl_oe_n) |-> irq_flag && sda_oe_n; endproperty
  a_st: assert property (p_st) else $error("bad stretch start");
  property p_irq; irq_flag && !irq_clear |=> irq_flag; endproperty
  a_irq: assert property (p_irq) else $error("irq lost");
  property p_hold; !scl_oe_n && !rel |=> !scl_oe_n; endproperty
  a_hold: assert property (p_hold) else $error("clock freed early");
  property p_rel; $rose(rel) |-> ##[0:1] scl_oe_n; endproperty
  a_rel: assert property (p_rel) else $error("clock not freed");
  property p_sda; $changed(sda_oe_n) |-> !scl_in; endproperty
  a_sda: assert property (p_sda) else $error("data moved high");
  property p_nack; $fell(status.read_direction) |-> scl_oe_n && sda_oe_n;
  endproperty
  a_nack: assert property (p_nack) else $error("lines held");
endmodule : ist_slave_tx_asserts
bind ist_slave_tx ist_slave_tx_asserts ist_slave_tx_asserts_i (.sys_clk,
  .rst, .match_in, .match_valid, .irq_clear, .ctl_rdata, .status,
  .irq_flag, .scl_in, .scl_oe_n, .sda_oe_n);
`default_nettype wire

// file: test/ist_master_model.sv
// Purpose: bus master receiver facing the slave-transmit block
// Assumes: open-drain wires with pull-ups resolved in the bench
// Notes:   clock half periods given per call
`timescale 1ns/1ns
`default_nettype none
module ist_master_model (
  input  wire logic sys_clk,  // clock
  input  wire logic scl,      // clock wire
  input  wire logic sda,      // data wire
  output var logic  scl_oe_n, // low: pull clock
  output var logic  sda_oe_n  // low: pull data
);
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end
  task automatic grab();
    @(posedge sys_clk);
    scl_oe_n <= 1'b0;
  endtask : grab
  task automatic free();
    @(posedge sys_clk);
    scl_oe_n <= 1'b1;
    sda_oe_n <= 1'b1;
  endtask : free
  // one clock pulse; drv pulls data low for the whole pulse
  task automatic pulse(input logic drv, input int lo, output logic s,
                       output logic late);
    int n;
    sda_oe_n <= ~drv;
    repeat (lo) @(posedge sys_clk);
    scl_oe_n <= 1'b1;
    n = 0;
    @(negedge sys_clk);
    while (!scl && n < 2000) begin
      n++;
      @(negedge sys_clk);
    end
    late = (n == 2000);
    repeat (lo) @(negedge sys_clk);
    s = sda;
    @(posedge sys_clk);
    scl_oe_n <= 1'b0;
  endtask : pulse
endmodule : ist_master_model
`default_nettype wire

// file: test/ist_slave_tx_tb.sv
// Purpose: self-checking bench for the slave-transmit block
// Assumes: software side driven as plain ports
// Notes:   bytes and clock timing random, seed 3
`timescale 1ns/1ns
`default_nettype none
module ist_slave_tx_tb;
  import ist_pkg::*;
  logic        sys_clk, rst, match_valid, wr_valid, wr_ready, ctl_we;
  logic        irq_clear, irq_flag, scl_oe_n, sda_oe_n, m_scl_n, m_sda_n;
  logic        s, l;
  logic [7:0]  wr_data, ctl_wdata, data_buffer, ctl_rdata, a, b;
  logic [7:0]  q[$];
  ist_match_s  match_in;
  ist_status_s status;
  int          bad_count, checks_done, lo, t, k;
  wire logic   scl_w = scl_oe_n & m_scl_n;
  wire logic   sda_w = sda_oe_n & m_sda_n;
  ist_slave_tx ist_slave_tx_i (.sys_clk, .rst, .match_in, .match_valid,
    .wr_data, .wr_valid, .wr_ready, .ctl_wdata, .ctl_we, .irq_clear,
    .data_buffer, .ctl_rdata, .status, .irq_flag, .scl_in(scl_w),
    .scl_oe_n, .sda_in(sda_w), .sda_oe_n);
  ist_master_model mdl (.sys_clk, .scl(scl_w), .sda(sda_w),
    .scl_oe_n(m_scl_n), .sda_oe_n(m_sda_n));
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task end_sim();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  task late_chk(input logic x);
    chk(x, 8'h00);
    if (x) end_sim();
  endtask : late_chk
  task push(input logic [7:0] d);
    int n;
    wr_data <= d;
    wr_valid <= 1'b1;
    n = 0;
    @(negedge sys_clk);
    while (!wr_ready && n < 50) begin
      n++;
      @(negedge sys_clk);
    end
    late_chk(n == 50);
    @(posedge sys_clk);
    q.push_back(d);
  endtask : push
  task clr_irq();
    irq_clear <= 1'b1;
    @(posedge sys_clk);
    irq_clear <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(irq_flag, 8'h00);
  endtask : clr_irq
  // late release keeps the master waiting on a stretched clock
  task release_clk();
    repeat (30) @(posedge sys_clk);
    ctl_wdata <= 8'h01 << CTL_CLOCK_RELEASE_BIT;
    ctl_we <= 1'b1;
    @(posedge sys_clk);
    ctl_we <= 1'b0;
  endtask : release_clk
  task rx(input logic ack);
    int i;
    for (i = 0; i < 8; i++) begin
      mdl.pulse(1'b0, lo, s, l);
      late_chk(l);
      b = {b[6:0], s};
    end
    mdl.pulse(ack, lo, s, l);
    late_chk(l);
  endtask : rx
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    rst = 1'b1;
    {match_valid, wr_valid, ctl_we, irq_clear} = 4'h0;
    {match_in, wr_data, ctl_wdata} = '0;
    bad_count = 0;
    checks_done = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    void'($urandom(3));
    @(posedge sys_clk);
    match_in <= '{addr_byte: 8'hA4, read_dir: 1'b0};
    match_valid <= 1'b1;
    @(posedge sys_clk);
    match_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({status, sda_oe_n}, 8'h01);
    chk(ctl_rdata, 8'h00);
    for (t = 0; t < 2; t++) begin
      lo = 6 + $urandom % 15;
      a = {7'($urandom), 1'b1};
      mdl.grab();
      repeat (8) @(posedge sys_clk);
      match_in <= '{addr_byte: a, read_dir: 1'b1};
      match_valid <= 1'b1;
      @(posedge sys_clk);
      match_valid <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk(status.read_direction, 8'h01);
      chk(data_buffer, a);
      mdl.pulse(1'b0, lo, s, l);
      late_chk(l);
      chk(s, 8'h00);
      repeat (8) @(posedge sys_clk);
      chk({irq_flag, scl_oe_n, sda_oe_n}, 8'h05);
      for (k = 0; k < 3; k++) push(8'($urandom));
      wr_valid <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk(wr_ready, 8'h00);
      for (k = 0; k < 3; k++) begin
        clr_irq();
        chk(data_buffer, q[0]);
        fork
          release_clk();
          rx(k != 2);
        join
        chk(b, q.pop_front());
        repeat (8) @(posedge sys_clk);
        chk({irq_flag, scl_oe_n, k == 2 ? {sda_oe_n, status} : 4'h0},
            k == 2 ? 8'h38 : 8'h20);
        chk(ctl_rdata, k == 2 ? 8'h10 : 8'h00);
      end
      chk(wr_ready, 8'h01);
      clr_irq();
      mdl.free();
      repeat (20) @(posedge sys_clk);
    end
    end_sim();
  end
endmodule : ist_slave_tx_tb
`default_nettype wire
